// ### hw/tsu_pkg.sv
// Package for the tick timer and supervisor unit: offsets, fields, resets
package tsu_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets (word index on the register port)
   localparam logic [2:0] OFS_UNIT_CONFIG       = 3'h0;
   localparam logic [2:0] OFS_PRESCALE_RATIO    = 3'h1;
   localparam logic [2:0] OFS_PERIODIC_PRESET   = 3'h2;
   localparam logic [2:0] OFS_TIMER_CTRL_STATUS = 3'h3;
   localparam logic [2:0] OFS_SUPERVISOR_COUNT  = 3'h4;
   localparam logic [2:0] OFS_MATCH_SERVICE     = 3'h5;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CFG_LOCK_CONFIG          = 0;
   localparam int CFG_LOCK_PRESCALE        = 1;
   localparam int CFG_LOCK_PERIODIC        = 2;
   localparam int CFG_LOCK_SUPERVISOR_CNT  = 3;
   localparam int CFG_SUP_CLK_FROM_TICK    = 4;
   localparam int CFG_MATCH_SERVICE_ENABLE = 5;
   localparam int CFG_WIDTH                = 6;
   localparam int CFG_LOCK_WIDTH           = 4;
   localparam int TCS_RESTART              = 0;
   localparam int TCS_TERMINAL_COUNT       = 1;
   localparam int EXP_WIDTH                = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and constants
   localparam logic [5:0]  RST_UNIT_CONFIG      = 6'h00;
   localparam logic [2:0]  RST_PRESCALE_RATIO   = 3'h0;
   localparam logic [15:0] RST_PERIODIC_PRESET  = 16'hffff;
   localparam logic [7:0]  RST_SUPERVISOR_COUNT = 8'h0f;
   localparam logic [7:0]  RESTART_MATCH_BYTE   = 8'h5c;
   localparam logic [2:0]  EXP_MAX_LEGAL        = 3'h5;
   localparam logic [4:0]  PRE_MASK_MAX         = 5'h1f;

   typedef enum logic [0:0] {
      SUP_OFF = 1'b0,
      SUP_RUN = 1'b1
   } tsu_sup_e;

endpackage

// ### hw/tsu_top.sv
// Tick timer with periodic down-counter and software supervisor
//
// Contract
// - Prescaler divides slow clock by two-power exponent.
// - 16-bit periodic down-counter auto-reloads preset.
// - Zero pulse lasts one prescaled tick.
// - Preset writes take effect at next reload.
// - Restart bit reloads on next tick, self-clears.
// - Terminal flag set at zero, cleared by read.
// - Preset resets to ffff; software writes nonzero.
// - Supervisor 8-bit, disabled and silent after reset.
// - First count or match write starts supervisor.
// - Unlocked count write reloads supervisor from value.
// - Match byte reloads; other byte raises failure.
// - Match writes ignored while match service disabled.
// - Supervisor reaching zero raises failure.
// - Two services in one supervisor clock fail.
// - Config bit 4 selects clock; pin overrides.
// - Lock bits freeze config, prescale, count registers.
// - Periodic lock freezes preset and control writes.
// - Config, prescale, control clear on reset.
// - Supervisor count write-only, resets to 0f.
// - Counters keep running in idle mode.
// - Writes may land up to three slow cycles.
// - Second match service within one clock fails.
`timescale 1ns/100ps
module tsu_top
   import tsu_pkg::*;
#(
   parameter int PRESET_WIDTH = 16,
   parameter int SUP_WIDTH    = 8
) (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        arst_n_i,
   // Pins from outside the clock domain
   input  wire logic        slow_clk_i,
   input  wire logic        alt_clk_i,
   input  wire logic        alt_clk_sel_i,
   // Register port
   input  wire logic [2:0]  addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   output logic      [15:0] rd_data_o,
   // Timer and supervisor outputs
   output logic             timer_zero_pulse_o,
   output logic             sup_fail_o,
   output logic             sup_running_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                    slow_meta;
      logic                    slow_sync;
      logic                    slow_prev;
      logic                    alt_meta;
      logic                    alt_sync;
      logic                    alt_prev;
      logic                    sel_meta;
      logic                    sel_sync;
      logic [4:0]              pre_cnt;
      logic [CFG_WIDTH-1:0]    cfg;
      logic [EXP_WIDTH-1:0]    prescale;
      logic [PRESET_WIDTH-1:0] preset;
      logic                    restart;
      logic                    tc;
      logic [PRESET_WIDTH-1:0] tmr_cnt;
      logic                    zero_out;
      tsu_sup_e                sup_state;
      logic [SUP_WIDTH-1:0]    sup_count;
      logic [SUP_WIDTH-1:0]    sup_cnt;
      logic                    serviced;
      logic                    fail;
      logic [15:0]             rdata;
   } tsu_state_s;

   tsu_state_s state_reg;
   tsu_state_s state_next;

   // Divide mask for an exponent; reserved codes act as the largest ratio
   function automatic logic [4:0] pre_mask(input logic [EXP_WIDTH-1:0] e);
      logic [4:0] m;
      m = PRE_MASK_MAX;
      if (e <= EXP_MAX_LEGAL) begin
         m = 5'((6'h01 << e) - 6'h01);
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and events

   logic                    slow_rise;
   logic                    tick;
   logic                    sup_edge;
   logic                    zero_hit;
   logic [PRESET_WIDTH-1:0] tmr_cnt_new;
   logic                    wr_cfg;
   logic                    wr_pre;
   logic                    wr_preset;
   logic                    wr_tcs;
   logic                    wr_count;
   logic                    wr_match;
   logic                    rd_tcs;
   logic                    match_good;
   logic                    match_bad;
   logic                    service;
   logic                    lock_config;
   logic                    lock_prescale;
   logic                    lock_periodic;
   logic                    lock_supervisor_count;

   assign lock_config           = state_reg.cfg[CFG_LOCK_CONFIG];
   assign lock_prescale         = state_reg.cfg[CFG_LOCK_PRESCALE];
   assign lock_periodic         = state_reg.cfg[CFG_LOCK_PERIODIC];
   assign lock_supervisor_count = state_reg.cfg[CFG_LOCK_SUPERVISOR_CNT];

   assign slow_rise = state_reg.slow_sync & ~state_reg.slow_prev;
   // A lowered exponent takes effect at the next slow edge, not after a wrap
   assign tick      = slow_rise
                      && (state_reg.pre_cnt >= pre_mask(state_reg.prescale));

   // Periodic counter next value on a tick
   always_comb begin
      if (state_reg.restart) begin
         tmr_cnt_new = state_reg.preset;
      end else if (state_reg.tmr_cnt == '0) begin
         tmr_cnt_new = state_reg.preset;
      end else begin
         tmr_cnt_new = state_reg.tmr_cnt - PRESET_WIDTH'(1);
      end
   end
   assign zero_hit = tick && (tmr_cnt_new == '0);

   // Supervisor clock: pin override, else config bit 4
   assign sup_edge = state_reg.sel_sync ? (state_reg.alt_sync & ~state_reg.alt_prev)
                   : state_reg.cfg[CFG_SUP_CLK_FROM_TICK] ? tick : zero_hit;

   assign wr_cfg    = wr_en_i && addr_i == OFS_UNIT_CONFIG && !lock_config;
   assign wr_pre    = wr_en_i && addr_i == OFS_PRESCALE_RATIO && !lock_prescale;
   assign wr_preset = wr_en_i && addr_i == OFS_PERIODIC_PRESET && !lock_periodic;
   assign wr_tcs    = wr_en_i && addr_i == OFS_TIMER_CTRL_STATUS && !lock_periodic;
   assign wr_count  = wr_en_i && addr_i == OFS_SUPERVISOR_COUNT
                      && !lock_supervisor_count;
   assign wr_match  = wr_en_i && addr_i == OFS_MATCH_SERVICE
                      && state_reg.cfg[CFG_MATCH_SERVICE_ENABLE];
   assign rd_tcs    = rd_en_i && addr_i == OFS_TIMER_CTRL_STATUS;
   assign match_good = wr_match && wr_data_i[7:0] == RESTART_MATCH_BYTE;
   assign match_bad  = wr_match && wr_data_i[7:0] != RESTART_MATCH_BYTE;
   assign service    = wr_count || match_good;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic running;
      logic fail_ev;
      running = 1'b0;
      fail_ev = 1'b0;
      state_next = state_reg;

      // Two-stage synchronisers
      state_next.slow_meta = slow_clk_i;
      state_next.slow_sync = state_reg.slow_meta;
      state_next.slow_prev = state_reg.slow_sync;
      state_next.alt_meta  = alt_clk_i;
      state_next.alt_sync  = state_reg.alt_meta;
      state_next.alt_prev  = state_reg.alt_sync;
      state_next.sel_meta  = alt_clk_sel_i;
      state_next.sel_sync  = state_reg.sel_meta;

      // Prescaler, runs regardless of idle mode
      if (tick) begin
         state_next.pre_cnt = '0;
      end else if (slow_rise) begin
         state_next.pre_cnt = state_reg.pre_cnt + 5'h01;
      end

      // Periodic timer
      if (tick) begin
         state_next.tmr_cnt  = tmr_cnt_new;
         state_next.restart  = 1'b0;
         state_next.zero_out = (tmr_cnt_new == '0);
      end
      if (zero_hit) begin
         state_next.tc = 1'b1;
      end else if (rd_tcs) begin
         state_next.tc = 1'b0;
      end

      // Register writes
      if (wr_cfg) begin
         state_next.cfg = wr_data_i[CFG_WIDTH-1:0];
         state_next.cfg[CFG_LOCK_WIDTH-1:0] = state_reg.cfg[CFG_LOCK_WIDTH-1:0]
                                             | wr_data_i[CFG_LOCK_WIDTH-1:0];
      end
      if (wr_pre) begin
         state_next.prescale = wr_data_i[EXP_WIDTH-1:0];
      end
      if (wr_preset) begin
         state_next.preset = wr_data_i[PRESET_WIDTH-1:0];
      end
      if (wr_tcs && wr_data_i[TCS_RESTART]) begin
         state_next.restart = 1'b1;
      end
      if (wr_count) begin
         state_next.sup_count = wr_data_i[SUP_WIDTH-1:0];
      end

      // Supervisor counting on its clock
      running = (state_reg.sup_state == SUP_RUN);
      if (running && sup_edge) begin
         state_next.serviced = 1'b0;
         if (state_reg.sup_cnt == SUP_WIDTH'(1) || state_reg.sup_cnt == '0) begin
            fail_ev = 1'b1;
            state_next.sup_cnt = state_reg.sup_count;
         end else begin
            state_next.sup_cnt = state_reg.sup_cnt - SUP_WIDTH'(1);
         end
      end

      // Service and start
      if (service || match_bad) begin
         state_next.sup_state = SUP_RUN;
      end
      if (service) begin
         if (running && state_reg.serviced && !(sup_edge)) begin
            fail_ev = 1'b1;
         end
         state_next.serviced = 1'b1;
         state_next.sup_cnt  = wr_count ? wr_data_i[SUP_WIDTH-1:0]
                                        : state_reg.sup_count;
      end
      if (match_bad) begin
         fail_ev = 1'b1;
      end

      // Failure stands until the next slow clock edge
      if (fail_ev) begin
         state_next.fail = 1'b1;
      end else if (slow_rise) begin
         state_next.fail = 1'b0;
      end

      // Read data, locked config, prescale or preset and write-only registers read zero
      state_next.rdata = '0;
      if (rd_en_i) begin
         unique case (addr_i)
            OFS_UNIT_CONFIG: begin
               if (!lock_config) begin
                  state_next.rdata = 16'(state_reg.cfg);
               end
            end
            OFS_PRESCALE_RATIO: begin
               if (!lock_prescale) begin
                  state_next.rdata = 16'(state_reg.prescale);
               end
            end
            OFS_PERIODIC_PRESET: begin
               if (!lock_periodic) begin
                  state_next.rdata = 16'(state_reg.preset);
               end
            end
            OFS_TIMER_CTRL_STATUS: begin
               state_next.rdata[TCS_RESTART]        = state_reg.restart;
               state_next.rdata[TCS_TERMINAL_COUNT] = state_reg.tc;
            end
            default: begin
               state_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg           <= '0;
         state_reg.cfg       <= RST_UNIT_CONFIG;
         state_reg.prescale  <= RST_PRESCALE_RATIO;
         state_reg.preset    <= RST_PERIODIC_PRESET;
         state_reg.tmr_cnt   <= RST_PERIODIC_PRESET;
         state_reg.sup_state <= SUP_OFF;
         state_reg.sup_count <= RST_SUPERVISOR_COUNT;
         state_reg.sup_cnt   <= RST_SUPERVISOR_COUNT;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_o          = state_reg.rdata;
   assign timer_zero_pulse_o = state_reg.zero_out;
   assign sup_fail_o         = state_reg.fail;
   assign sup_running_o      = (state_reg.sup_state == SUP_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   a_prescale_ratio: assert property (tick |-> slow_rise
                                      && state_reg.pre_cnt >= pre_mask(state_reg.prescale))
      else $error("tick not at prescale terminal count");

   a_timer_reload: assert property (tick && state_reg.tmr_cnt == '0
                                    && !state_reg.restart
                                    |=> state_reg.tmr_cnt == $past(state_reg.preset))
      else $error("periodic counter did not reload preset");

   a_zero_pulse: assert property (tick && state_reg.zero_out
                                  && state_reg.preset != '0 |=> !state_reg.zero_out)
      else $error("zero pulse longer than one tick");

   a_restart_load: assert property (tick && state_reg.restart && !wr_tcs
                                    |=> !state_reg.restart
                                    && state_reg.tmr_cnt == $past(state_reg.preset))
      else $error("restart did not reload and clear");

   a_tc_set: assert property (zero_hit |=> state_reg.tc)
      else $error("terminal count not set at zero");

   a_tc_clear: assert property (rd_tcs && !zero_hit |=> !state_reg.tc)
      else $error("terminal count not cleared by read");

   a_off_silent: assert property (state_reg.sup_state == SUP_OFF |-> !state_reg.fail)
      else $error("failure while supervisor disabled");

   a_running_kept: assert property (sup_running_o |=> sup_running_o)
      else $error("supervisor stopped without reset");

   a_count_load: assert property (wr_count
                                  |=> state_reg.sup_cnt == SUP_WIDTH'($past(wr_data_i)))
      else $error("count write did not restart supervisor");

   a_match_ignored: assert property (wr_en_i && addr_i == OFS_MATCH_SERVICE
                                     && !state_reg.cfg[CFG_MATCH_SERVICE_ENABLE] && !sup_edge
                                     |=> $stable(state_reg.sup_cnt)
                                     && $stable(state_reg.sup_state))
      else $error("disabled match write took effect");

   a_late_fail: assert property (sup_running_o && sup_edge
                                 && state_reg.sup_cnt == SUP_WIDTH'(1) |=> state_reg.fail)
      else $error("no failure on supervisor expiry");

   a_early_fail: assert property (sup_running_o && service
                                  && state_reg.serviced && !sup_edge |=> state_reg.fail)
      else $error("no failure on early service");

   a_match_reload: assert property (match_good && !sup_edge
                                    |=> state_reg.sup_cnt == $past(state_reg.sup_count))
      else $error("match service did not reload");

   a_cfg_locked: assert property (wr_en_i && addr_i == OFS_UNIT_CONFIG
                                  && lock_config |=> $stable(state_reg.cfg))
      else $error("locked config changed");

   a_count_locked: assert property (wr_en_i && addr_i == OFS_SUPERVISOR_COUNT
                                    && lock_supervisor_count |=> $stable(state_reg.sup_count))
      else $error("locked supervisor count changed");

   a_preset_locked: assert property (wr_en_i && addr_i == OFS_PERIODIC_PRESET
                                     && lock_periodic |=> $stable(state_reg.preset))
      else $error("locked preset changed");

   a_fail_clear: assert property (state_reg.fail && slow_rise && !sup_edge
                                  && !service && !match_bad |=> !state_reg.fail)
      else $error("failure outlasted a slow clock edge");

   c_zero_tick:   cover property (zero_hit);
   c_match_serve: cover property (match_good ##1 sup_running_o);
   c_late_fail:   cover property (sup_running_o && sup_edge && state_reg.sup_cnt == 8'h01);
   c_bad_match:   cover property (match_bad);
   c_alt_edge:    cover property (state_reg.sel_sync && sup_edge);

endmodule

// ### sim/tsu_top_tb.sv
// Self-checking bench for the tick timer and supervisor unit
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %0t: got %0h expected %0h", $time, (g), (e)); end end
module tsu_top_tb;
   import tsu_pkg::*;
   localparam int SP  = 20;    // Slow clock period in mclk cycles, shortened for run time
   localparam int LIM = 6000;
   typedef struct {
      logic [2:0]  a;
      logic        w;
      logic [15:0] d;
      logic [15:0] e;
   } tsu_row_s;

   logic        mclk_i        = 1'b0;
   logic        arst_n_i;
   logic        slow_clk_i    = 1'b0;
   logic        alt_clk_i;
   logic        alt_clk_sel_i;
   logic [2:0]  addr_i;
   logic [15:0] wr_data_i;
   logic        wr_en_i;
   logic        rd_en_i;
   logic [15:0] rd_data_o;
   logic        timer_zero_pulse_o;
   logic        sup_fail_o;
   logic        sup_running_o;
   logic [15:0] d;
   logic        fail_q        = 1'b0;
   int          n_mismatch    = 0;
   int          comparisons   = 0;
   int          n_fail        = 0;
   int          f0            = 0;
   int          sc_cnt        = 0;
   int          a;
   int          b;
   int          t;
   tsu_row_s    rows [11]     = '{
      '{OFS_UNIT_CONFIG,       1'b0, 16'h0000, 16'h0000},
      '{OFS_PRESCALE_RATIO,    1'b0, 16'h0000, 16'h0000},
      '{OFS_PERIODIC_PRESET,   1'b0, 16'h0000, 16'hffff},
      '{OFS_TIMER_CTRL_STATUS, 1'b0, 16'h0000, 16'h0000},
      '{OFS_SUPERVISOR_COUNT,  1'b0, 16'h0000, 16'h0000},
      '{OFS_MATCH_SERVICE,     1'b0, 16'h0000, 16'h0000},
      '{3'h6,                  1'b1, 16'hffff, 16'h0000},
      '{OFS_PRESCALE_RATIO,    1'b1, 16'h00fd, 16'h0005},
      '{OFS_TIMER_CTRL_STATUS, 1'b1, 16'h0002, 16'h0000},
      '{OFS_PERIODIC_PRESET,   1'b1, 16'h0001, 16'h0001},
      '{OFS_UNIT_CONFIG,       1'b1, 16'h0010, 16'h0010}
   };

   tsu_top uut (
      .mclk_i            (mclk_i),
      .arst_n_i          (arst_n_i),
      .slow_clk_i        (slow_clk_i),
      .alt_clk_i         (alt_clk_i),
      .alt_clk_sel_i     (alt_clk_sel_i),
      .addr_i            (addr_i),
      .wr_data_i         (wr_data_i),
      .wr_en_i           (wr_en_i),
      .rd_en_i           (rd_en_i),
      .rd_data_o         (rd_data_o),
      .timer_zero_pulse_o(timer_zero_pulse_o),
      .sup_fail_o        (sup_fail_o),
      .sup_running_o     (sup_running_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clocks and failure counter
   always #12.5 mclk_i = ~mclk_i;

   always @(posedge mclk_i) begin
      sc_cnt <= (sc_cnt == SP - 1) ? 0 : sc_cnt + 1;
      slow_clk_i <= (sc_cnt < SP / 2);
   end

   always @(posedge mclk_i) begin
      if (sup_fail_o === 1'b1 && fail_q === 1'b0) n_fail++;
      fail_q = sup_fail_o;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic close_out;
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic timed_out(input int n);
      if (n >= LIM) begin
         n_mismatch++;
         $display("FAIL %0t: wait ran out", $time);
         close_out;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   task automatic wr(input logic [2:0] ad, input logic [15:0] dat);
      @(posedge mclk_i);
      addr_i <= ad;
      wr_data_i <= dat;
      wr_en_i <= 1'b1;
      @(posedge mclk_i);
      wr_en_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] ad, output logic [15:0] dat);
      @(posedge mclk_i);
      addr_i <= ad;
      rd_en_i <= 1'b1;
      @(posedge mclk_i);
      rd_en_i <= 1'b0;
      #1 dat = rd_data_o;
   endtask

   task automatic wait_zp(input logic lvl, output int n);
      n = 0;
      #1;
      while (timer_zero_pulse_o !== lvl && n < LIM) begin
         @(posedge mclk_i);
         #1 n++;
      end
      timed_out(n);
   endtask

   task automatic near(input int got, input int exp);
      `CHK(got >= exp - 2 && got <= exp + 2, 1'b1)
   endtask

   // Align just after a timer zero event
   task automatic sync;
      wait_zp(1'b0, a);
      wait_zp(1'b1, a);
      cyc(10);
      f0 = n_fail;
   endtask

   task automatic fails(input int n, input int exp);
      cyc(n);
      #1 `CHK(n_fail - f0, exp)
   endtask

   task automatic fail_time(output int n);
      n = 0;
      while (n_fail == f0 && n < LIM) begin
         @(posedge mclk_i);
         #1 n++;
      end
      timed_out(n);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      arst_n_i = 1'b0;
      alt_clk_i = 1'b0;
      alt_clk_sel_i = 1'b0;
      addr_i = 3'h0;
      wr_data_i = 16'h0000;
      wr_en_i = 1'b0;
      rd_en_i = 1'b0;
      cyc(2);
      `CHK({timer_zero_pulse_o, sup_fail_o, sup_running_o, rd_data_o}, 19'h00000)
      cyc(2);
      arst_n_i <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, d);
         `CHK(d, rows[i].e)
      end
      // Every exponent code, preset 1: pulse one tick wide, period two ticks
      for (int e = 0; e < 8; e++) begin
         wr(OFS_PRESCALE_RATIO, 16'(e));
         wr(OFS_TIMER_CTRL_STATUS, 16'h0001);
         wait_zp(1'b1, a);
         wait_zp(1'b0, a);
         wait_zp(1'b1, a);
         wait_zp(1'b0, a);
         wait_zp(1'b1, b);
         near(a, SP << (e > 5 ? 5 : e));
         near(a + b, 2 * (SP << (e > 5 ? 5 : e)));
      end
      wr(OFS_PRESCALE_RATIO, 16'h0003);
      wait_zp(1'b0, a);
      wait_zp(1'b1, a);
      rd(OFS_TIMER_CTRL_STATUS, d);
      `CHK(d, 16'h0002)
      cyc(1);
      #1 `CHK(rd_data_o, 16'h0000)
      rd(OFS_TIMER_CTRL_STATUS, d);
      `CHK(d, 16'h0000)
      wait_zp(1'b0, a);
      wr(OFS_PERIODIC_PRESET, 16'h0003);
      wait_zp(1'b1, a);
      near(a + 2, 8 * SP);
      wait_zp(1'b0, a);
      wait_zp(1'b1, b);
      near(a + b, 32 * SP);
      wait_zp(1'b0, a);
      wr(OFS_TIMER_CTRL_STATUS, 16'h0001);
      wait_zp(1'b1, b);
      near(b + 2, 32 * SP);
      rd(OFS_TIMER_CTRL_STATUS, d);
      `CHK(d[0], 1'b0)
      // Supervisor on the tick clock, started by a match write
      wr(OFS_PRESCALE_RATIO, 16'h0000);
      wr(OFS_TIMER_CTRL_STATUS, 16'h0001);
      `CHK({sup_running_o, n_fail == 0}, 2'h1)
      wr(OFS_UNIT_CONFIG, 16'h0030);
      f0 = n_fail;
      // No idle entry is modelled after the supervisor starts
      wr(OFS_MATCH_SERVICE, 16'(RESTART_MATCH_BYTE));
      cyc(2);
      `CHK(sup_running_o, 1'b1)
      fail_time(t);
      `CHK(t >= 14 * SP - 4 && t <= 15 * SP + 6, 1'b1)
      f0 = n_fail;
      for (int i = 0; i < 5; i++) begin
         wr(OFS_SUPERVISOR_COUNT, 16'h0003);
         cyc(28);
      end
      `CHK(n_fail - f0, 0)
      wr(OFS_SUPERVISOR_COUNT, 16'h0003);
      fail_time(t);
      `CHK(t >= 2 * SP - 2 && t <= 3 * SP + 6, 1'b1)
      wr(OFS_SUPERVISOR_COUNT, 16'h00ff);
      wr(OFS_UNIT_CONFIG, 16'h0000);
      // Zero-pulse clock: early service, match service
      sync;
      wr(OFS_SUPERVISOR_COUNT, 16'h00ff);
      wr(OFS_SUPERVISOR_COUNT, 16'h00ff);
      fails(6, 1);
      sync;
      wr(OFS_MATCH_SERVICE, 16'h00a5);
      fails(6, 0);
      wr(OFS_UNIT_CONFIG, 16'h0020);
      sync;
      wr(OFS_MATCH_SERVICE, 16'(RESTART_MATCH_BYTE));
      fails(6, 0);
      sync;
      wr(OFS_MATCH_SERVICE, 16'(RESTART_MATCH_BYTE));
      wr(OFS_MATCH_SERVICE, 16'(RESTART_MATCH_BYTE));
      fails(6, 1);
      sync;
      wr(OFS_MATCH_SERVICE, 16'h00a5);
      fails(6, 1);
      // Alternate clock selection overrides the configuration
      sync;
      alt_clk_sel_i <= 1'b1;
      cyc(5);
      wr(OFS_SUPERVISOR_COUNT, 16'h0002);
      fails(400, 0);
      for (int i = 0; i < 2; i++) begin
         cyc(1);
         alt_clk_i <= 1'b1;
         cyc(6);
         alt_clk_i <= 1'b0;
         cyc(5);
      end
      fails(8, 1);
      wr(OFS_SUPERVISOR_COUNT, 16'h00ff);
      cyc(1);
      alt_clk_sel_i <= 1'b0;
      // Locks
      wr(OFS_UNIT_CONFIG, 16'h000f);
      rd(OFS_UNIT_CONFIG, d);
      `CHK(d, 16'h0000)
      rd(OFS_PERIODIC_PRESET, d);
      `CHK(d, 16'h0000)
      wr(OFS_UNIT_CONFIG, 16'h0020);
      sync;
      wr(OFS_MATCH_SERVICE, 16'h00a5);
      fails(6, 0);
      wr(OFS_PRESCALE_RATIO, 16'h0003);
      wr(OFS_PERIODIC_PRESET, 16'h0001);
      wr(OFS_TIMER_CTRL_STATUS, 16'h0001);
      wait_zp(1'b0, a);
      wait_zp(1'b1, a);
      wait_zp(1'b0, a);
      wait_zp(1'b1, b);
      near(a + b, 4 * SP);
      sync;
      wr(OFS_SUPERVISOR_COUNT, 16'h0001);
      wr(OFS_SUPERVISOR_COUNT, 16'h0001);
      fails(100, 0);
      // Second reset releases the locks and stops the supervisor
      cyc(1);
      arst_n_i <= 1'b0;
      cyc(4);
      `CHK(sup_running_o, 1'b0)
      arst_n_i <= 1'b1;
      wr(OFS_UNIT_CONFIG, 16'h0010);
      rd(OFS_UNIT_CONFIG, d);
      `CHK(d, 16'h0010)
      rd(OFS_PERIODIC_PRESET, d);
      `CHK(d, RST_PERIODIC_PRESET)
      close_out;
   end
endmodule
